// ===== rtl/rbl_pkg.sv
// package: timing constants, modes and carriers for the reset button and led block
package rbl_pkg;
  // clock rate and button debounce time
  localparam int unsigned ClkHz = 250_000_000;
  localparam int unsigned DebounceMs = 20;
  localparam int unsigned DebounceCycles = (ClkHz / 1000) * DebounceMs;
  // hold window edges in seconds
  localparam logic [5:0] RebootStartSec = 6'h05;
  localparam logic [5:0] RebootEndSec = 6'h0f;
  localparam logic [5:0] AccessEndSec = 6'h12;
  localparam logic [5:0] FactoryStartSec = 6'h1e;
  localparam logic [5:0] FactoryEndSec = 6'h21;
  localparam logic [5:0] HoldSatSec = 6'h3f;
  // blink rates in tenth-second ticks (half periods; the sleep pair give period and on time)
  localparam int unsigned TenthSec = 10;
  localparam logic [4:0] SlowHalf = 5'h05;
  localparam logic [4:0] FastHalf = 5'h02;
  localparam logic [4:0] CompHalf = 5'h02;
  localparam logic [4:0] AltSlowHalf = 5'h0a;
  localparam logic [4:0] SaveHalf = 5'h05;
  localparam logic [4:0] SleepPeriod = 5'h1e;
  localparam logic [4:0] SleepOn = 5'h02;
  localparam logic [4:0] GpsHalf = 5'h05;
  // signal level threshold in dBm, two's complement
  localparam logic signed [7:0] StrongSigDbm = -8'sd80;

  typedef enum logic [3:0] {
    ActNone = 4'h0,
    ActReboot = 4'h1,
    ActAccess = 4'h2,
    ActFactory = 4'h4,
    ActPurge = 4'h8
  } rbl_action_type;

  typedef enum logic [1:0] {
    PwrNormal = 2'h0,
    PwrSave = 2'h1,
    PwrSleep = 2'h2
  } rbl_power_type;

  // flash disc state as reported by the file handler
  typedef struct packed {
    logic present;
    logic fat32;
    logic done;
    logic fwFound;
    logic inFiles;
  } rbl_disc_type;

  typedef struct packed {
    logic red;
    logic green;
  } rbl_led_type;

  // alarm inputs: one item's out-of-threshold flag and its enabled actions
  typedef struct packed {
    logic outOfRange;
    logic notifyEn;
    logic alarmOutEn;
    logic graphEn;
  } rbl_alarm_type;
endpackage

// ===== rtl/rbl_reset_led.sv
// reset button timing, service actions and front panel indicator patterns
// Function
// - release between 5 and 15 s held reboots the device in either security mode
// - security off: 15-18 s restores access defaults, 30-33 s factory; then reboot
// - security on: 15-18 s release purges everything then reboots; no factory window
// - status dark first 5 s, green flash from 5, faster 15-18, red fast 30-33 with security off
// - disc seen: slow red/green alternation; done: fast alternation 2.5 per second
// - power green steady; 1 s period blink in save; one flash per 3 s sleep
// - tx green 1 s blink while time receiver synced; red while transmitting
// - rx green while packet sync; yellow when channel signal above -80 dBm
// - status steady red on enabled alarm; fast red flashing in emergency
// - firmware file in disc root starts upgrade automatically; newest chosen
// - non FAT32 disc ignored; valid disc without inputs only gathers data
module rbl_reset_led #(
  parameter int unsigned TenthCycles = rbl_pkg::ClkHz / rbl_pkg::TenthSec
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic buttonPressedN,
  input wire logic physSecurity,
  input wire logic emergency,
  input wire rbl_pkg::rbl_alarm_type alarm,
  input wire rbl_pkg::rbl_disc_type disc,
  input wire rbl_pkg::rbl_power_type powerMode,
  input wire logic gpsFitted,
  input wire logic gpsSynced,
  input wire logic transmitting,
  input wire logic packetSync,
  input wire logic signed [7:0] signalDbm,
  output rbl_pkg::rbl_action_type action,
  output logic actionStrobe,
  output logic upgradeStart,
  output logic gatherOnly,
  output rbl_pkg::rbl_led_type statusLed,
  output rbl_pkg::rbl_led_type powerLed,
  output rbl_pkg::rbl_led_type txLed,
  output rbl_pkg::rbl_led_type rxLed
);
  // ****************************************************
  // input synchronisers and debounce
  // ****************************************************
  logic [1:0] btnSync_q;
  logic btnStable_q;
  logic [23:0] dbCnt_q;
  logic btnRaw;
  // debounce follows the timebase, so a shortened simulation tenth shortens it too
  localparam int unsigned TimeScale = rbl_pkg::ClkHz / rbl_pkg::TenthSec / TenthCycles;
  localparam int unsigned DbCycles = rbl_pkg::DebounceCycles / TimeScale;
  assign btnRaw = ~btnSync_q[1];
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      btnSync_q <= 2'h3;
    end else begin
      btnSync_q <= {btnSync_q[0], buttonPressedN};
    end
  end
  // a level must hold the whole debounce time before it counts
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dbCnt_q <= 24'h000000;
      btnStable_q <= 1'b0;
    end else if (btnRaw == btnStable_q) begin
      dbCnt_q <= 24'h000000;
    end else if (dbCnt_q == 24'(DbCycles - 1)) begin
      dbCnt_q <= 24'h000000;
      btnStable_q <= btnRaw;
    end else begin
      dbCnt_q <= dbCnt_q + 24'h000001;
    end
  end

  // ****************************************************
  // tenth-second timebase and hold timer
  // ****************************************************
  logic [27:0] preCnt_q;
  logic tick;
  logic [3:0] tenths_q;
  logic [5:0] holdSec_q;
  logic btnPrev_q;
  logic [4:0] free_q;
  assign tick = preCnt_q == 28'(TenthCycles - 1);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      preCnt_q <= 28'h0000000;
      free_q <= 5'h00;
    end else begin
      preCnt_q <= tick ? 28'h0000000 : preCnt_q + 28'h0000001;
      if (tick) begin
        free_q <= (free_q == rbl_pkg::SleepPeriod - 5'h01) ? 5'h00 : free_q + 5'h01;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tenths_q <= 4'h0;
      holdSec_q <= 6'h00;
      btnPrev_q <= 1'b0;
    end else begin
      btnPrev_q <= btnStable_q;
      if (!btnStable_q) begin
        tenths_q <= 4'h0;
        holdSec_q <= 6'h00;
      end else if (tick) begin
        tenths_q <= (tenths_q == 4'h9) ? 4'h0 : tenths_q + 4'h1;
        if (tenths_q == 4'h9 && holdSec_q != rbl_pkg::HoldSatSec) begin
          holdSec_q <= holdSec_q + 6'h01;
        end
      end
    end
  end

  // ****************************************************
  // window decode and release action
  // ****************************************************
  function automatic logic inWin(input logic [5:0] s, input logic [5:0] lo,
                                 input logic [5:0] hi);
    inWin = (s >= lo) && (s < hi);
  endfunction
  logic winReboot, winMid, winFactory, released;
  rbl_pkg::rbl_action_type action_d, action_q;
  assign winReboot = inWin(holdSec_q, rbl_pkg::RebootStartSec, rbl_pkg::RebootEndSec);
  assign winMid = inWin(holdSec_q, rbl_pkg::RebootEndSec, rbl_pkg::AccessEndSec);
  // factory window only exists with security off
  assign winFactory = !physSecurity &&
    inWin(holdSec_q, rbl_pkg::FactoryStartSec, rbl_pkg::FactoryEndSec);
  assign released = btnPrev_q && !btnStable_q;
  always_comb begin
    action_d = rbl_pkg::ActNone;
    if (winReboot) begin
      action_d = rbl_pkg::ActReboot;
    end else if (winMid) begin
      action_d = physSecurity ? rbl_pkg::ActPurge : rbl_pkg::ActAccess;
    end else if (winFactory) begin
      action_d = rbl_pkg::ActFactory;
    end
  end
  logic strobe_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      action_q <= rbl_pkg::ActNone;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= released && action_d != rbl_pkg::ActNone;
      if (released) begin
        action_q <= action_d;
      end
    end
  end
  assign action = action_q;
  assign actionStrobe = strobe_q;

  // ****************************************************
  // flash disc handling
  // ****************************************************
  logic discOk, upg_q, gather_q, discPrev_q;
  assign discOk = disc.present && disc.fat32;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      upg_q <= 1'b0;
      gather_q <= 1'b0;
      discPrev_q <= 1'b0;
    end else begin
      discPrev_q <= discOk;
      // newest package is picked by the file handler; any package starts it
      upg_q <= discOk && !discPrev_q && disc.fwFound;
      gather_q <= discOk && !disc.inFiles;
    end
  end
  assign upgradeStart = upg_q;
  assign gatherOnly = gather_q;

  // ****************************************************
  // indicator patterns
  // ****************************************************
  function automatic logic blink(input logic [4:0] t, input logic [4:0] half);
    blink = ((t / half) % 5'h02) == 5'h00;
  endfunction
  rbl_pkg::rbl_led_type stat_d, stat_q, pwr_d, pwr_q, tx_d, tx_q, rx_d, rx_q;
  logic alarmOn, slowPh, fastPh, compPh, altPh;
  assign alarmOn = alarm.outOfRange &&
    (alarm.notifyEn || alarm.alarmOutEn || alarm.graphEn);
  assign slowPh = blink(free_q, rbl_pkg::SlowHalf);
  assign fastPh = blink(free_q, rbl_pkg::FastHalf);
  assign compPh = blink(free_q, rbl_pkg::CompHalf);
  assign altPh = blink(free_q, rbl_pkg::AltSlowHalf);
  // button feedback outranks the disc, disc outranks emergency and alarm
  always_comb begin
    stat_d = '{red: 1'b0, green: 1'b1};
    if (btnStable_q) begin
      if (holdSec_q < rbl_pkg::RebootStartSec) begin
        stat_d = '{red: 1'b0, green: 1'b0};
      end else if (winReboot) begin
        stat_d = '{red: 1'b0, green: slowPh};
      end else if (winMid) begin
        stat_d = '{red: 1'b0, green: fastPh};
      end else if (winFactory) begin
        stat_d = '{red: fastPh, green: 1'b0};
      end else begin
        stat_d = '{red: 1'b0, green: 1'b0};
      end
    end else if (discOk && disc.done) begin
      stat_d = '{red: !compPh, green: compPh};
    end else if (discOk) begin
      stat_d = '{red: !altPh, green: altPh};
    end else if (emergency) begin
      stat_d = '{red: fastPh, green: 1'b0};
    end else if (alarmOn) begin
      stat_d = '{red: 1'b1, green: 1'b0};
    end
  end
  always_comb begin
    unique case (powerMode)
      rbl_pkg::PwrSave: pwr_d = '{red: 1'b0, green: blink(free_q, rbl_pkg::SaveHalf)};
      rbl_pkg::PwrSleep: pwr_d = '{red: 1'b0, green: free_q < rbl_pkg::SleepOn};
      default: pwr_d = '{red: 1'b0, green: 1'b1};
    endcase
  end
  // transmit red wins over the sync blink
  logic gpsOn, strongSig;
  assign gpsOn = gpsFitted && gpsSynced && blink(free_q, rbl_pkg::GpsHalf);
  assign tx_d = transmitting ? rbl_pkg::rbl_led_type'{red: 1'b1, green: 1'b0} :
    rbl_pkg::rbl_led_type'{red: 1'b0, green: gpsOn};
  // yellow is both colours lit
  assign strongSig = signalDbm > rbl_pkg::StrongSigDbm;
  assign rx_d = strongSig ? rbl_pkg::rbl_led_type'{red: 1'b1, green: 1'b1} :
    rbl_pkg::rbl_led_type'{red: 1'b0, green: packetSync};
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat_q <= '{red: 1'b0, green: 1'b0};
      pwr_q <= '{red: 1'b0, green: 1'b0};
      tx_q <= '{red: 1'b0, green: 1'b0};
      rx_q <= '{red: 1'b0, green: 1'b0};
    end else begin
      stat_q <= stat_d;
      pwr_q <= pwr_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
    end
  end
  assign statusLed = stat_q;
  assign powerLed = pwr_q;
  assign txLed = tx_q;
  assign rxLed = rx_q;
endmodule

// ===== verification/rbl_operator.sv
// operator model: presses the service button and lets it go
module rbl_operator (
  input wire logic ref_clk,
  output logic buttonPressedN
);
  timeunit 1ns;
  timeprecision 1ps;
  // pin is pulled up, so a released button reads high
  initial buttonPressedN = 1'b1;
  // the caller adds the press debounce to the count of falling edges held
  task automatic hold(input int unsigned cycles);
    @(negedge ref_clk);
    buttonPressedN = 1'b0;
    repeat (cycles) @(negedge ref_clk);
    buttonPressedN = 1'b1;
  endtask
endmodule

// ===== verification/rbl_reset_led_checker.sv
// checker: port assertions for the reset button and led block
module rbl_reset_led_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic physSecurity,
  input wire logic transmitting,
  input wire logic signed [7:0] signalDbm,
  input wire rbl_pkg::rbl_power_type powerMode,
  input wire rbl_pkg::rbl_action_type action,
  input wire logic actionStrobe,
  input wire logic upgradeStart,
  input wire rbl_pkg::rbl_led_type powerLed,
  input wire rbl_pkg::rbl_led_type txLed,
  input wire rbl_pkg::rbl_led_type rxLed
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_strobe_act;
    actionStrobe |-> action != rbl_pkg::ActNone ##1 $stable(action);
  endproperty
  a_strobe_act: assert property (p_strobe_act) else $error("strobe without action");
  property p_strobe_once;
    actionStrobe |=> !actionStrobe;
  endproperty
  a_strobe_once: assert property (p_strobe_once) else $error("strobe too long");
  property p_strobe_follow;
    $changed(action) && action != rbl_pkg::ActNone |-> actionStrobe;
  endproperty
  a_strobe_follow: assert property (p_strobe_follow) else $error("strobe missing");
  property p_sec_on;
    $changed(action) && physSecurity |->
      !(action inside {rbl_pkg::ActAccess, rbl_pkg::ActFactory});
  endproperty
  a_sec_on: assert property (p_sec_on) else $error("restore with security on");
  property p_sec_off;
    $changed(action) && !physSecurity |-> action != rbl_pkg::ActPurge;
  endproperty
  a_sec_off: assert property (p_sec_off) else $error("purge with security off");
  property p_pwr;
    !$past(rst) && $past(powerMode) == rbl_pkg::PwrNormal |-> powerLed == 2'b01;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power led not steady green");
  property p_rx;
    !$past(rst) |-> rxLed.red == ($past(signalDbm) > rbl_pkg::StrongSigDbm);
  endproperty
  a_rx: assert property (p_rx) else $error("receive yellow wrong");
  property p_tx;
    !$past(rst) |-> txLed.red == $past(transmitting);
  endproperty
  a_tx: assert property (p_tx) else $error("transmit red wrong");
  property p_upg;
    upgradeStart |=> !upgradeStart;
  endproperty
  a_upg: assert property (p_upg) else $error("upgrade pulse too long");
  c_reboot: cover property (actionStrobe && action == rbl_pkg::ActReboot);
  c_access: cover property (actionStrobe && action == rbl_pkg::ActAccess);
  c_purge: cover property (actionStrobe && action == rbl_pkg::ActPurge);
endmodule
bind rbl_reset_led rbl_reset_led_checker u_chk (.ref_clk, .rst, .physSecurity, .transmitting,
  .signalDbm, .powerMode, .action, .actionStrobe, .upgradeStart, .powerLed, .txLed, .rxLed);

// ===== verification/rbl_reset_led_tb.sv
// testbench: service button actions and indicator patterns
module rbl_reset_led_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, buttonPressedN, physSecurity, emergency, gpsFitted, gpsSynced;
  logic transmitting, packetSync, actionStrobe, upgradeStart, gatherOnly;
  logic signed [7:0] signalDbm;
  rbl_pkg::rbl_alarm_type alarm;
  rbl_pkg::rbl_disc_type disc;
  rbl_pkg::rbl_power_type powerMode;
  rbl_pkg::rbl_action_type action;
  rbl_pkg::rbl_led_type statusLed, powerLed, txLed, rxLed;
  int mismatches = 0;
  int n_compared = 0;
  rbl_operator u_op (.ref_clk, .buttonPressedN);
  // a tenth of a second is 10 cycles, so one second is 100
  localparam int unsigned SimTenth = 10;
  // 20 ms is a fifth of a tenth, so the debounce shrinks with the timebase
  localparam int unsigned SimDebounce = rbl_pkg::DebounceMs * rbl_pkg::TenthSec * SimTenth / 1000;
  rbl_reset_led #(.TenthCycles(SimTenth)) u_dut (.ref_clk, .rst, .buttonPressedN, .physSecurity,
    .emergency, .alarm, .disc, .powerMode, .gpsFitted, .gpsSynced, .transmitting, .packetSync,
    .signalDbm, .action, .actionStrobe, .upgradeStart, .gatherOnly, .statusLed, .powerLed,
    .txLed, .rxLed);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // release lands half way through a second; status must be dark early in the hold
  task automatic press(input int sec, input logic secOn, input rbl_pkg::rbl_action_type exp);
    int n;
    int g;
    physSecurity = secOn;
    fork
      u_op.hold(SimDebounce + sec * 100 + 50);
      begin
        repeat (SimDebounce + 300) @(negedge ref_clk);
        check(statusLed, 16'h0000, "status dark");
        // six seconds in: one whole slow period inside the reboot window
        repeat (300) @(negedge ref_clk);
        g = 0;
        repeat (100) begin
          @(negedge ref_clk);
          g += (statusLed === 2'b01);
        end
        check(g, 50, "status slow green");
      end
    join
    n = 0;
    while (actionStrobe !== 1'b1 && n < SimDebounce + 20) begin
      @(negedge ref_clk);
      n++;
    end
    check(actionStrobe, exp != rbl_pkg::ActNone, "strobe");
    check(action, exp, "action");
    if (actionStrobe !== (exp != rbl_pkg::ActNone)) conclude();
  endtask
  // count lit cycles over three seconds, one whole wrap of the free-running counter behind every pattern
  task automatic window(input int pwrOn, input int redOn, input int txOn);
    int p, r, t;
    p = 0;
    r = 0;
    t = 0;
    repeat (300) begin
      @(negedge ref_clk);
      p += (powerLed === 2'b01);
      r += (statusLed === 2'b10);
      t += (txLed === 2'b01);
    end
    check(p, pwrOn, "power on count");
    check(r, redOn, "status red count");
    check(t, txOn, "tx green count");
  endtask
  initial begin
    rst = 1'b1;
    {physSecurity, emergency, gpsFitted, gpsSynced, transmitting, packetSync} = '0;
    alarm = '0;
    disc = '0;
    powerMode = rbl_pkg::PwrNormal;
    signalDbm = -8'sd90;
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    check(action, rbl_pkg::ActNone, "action idle");
    check(statusLed, 16'h0001, "status green");
    transmitting = 1'b1;
    signalDbm = -8'sd79;
    repeat (2) @(negedge ref_clk);
    check(txLed.red, 1'b1, "tx red");
    check(rxLed, 16'h0003, "rx yellow");
    signalDbm = -8'sd80;
    packetSync = 1'b1;
    alarm = '{1'b1, 1'b1, 1'b0, 1'b0};
    repeat (2) @(negedge ref_clk);
    check(rxLed, 16'h0001, "rx green at threshold");
    check(statusLed, 16'h0002, "status alarm");
    alarm = '{1'b1, 1'b0, 1'b0, 1'b0};
    repeat (2) @(negedge ref_clk);
    check(statusLed, 16'h0001, "alarm without action");
    powerMode = rbl_pkg::PwrSave;
    emergency = 1'b1;
    transmitting = 1'b0;
    {gpsFitted, gpsSynced} = 2'b11;
    // fast phases do not divide three seconds, so the wrap adds one lit fast step
    window(150, 160, 150);
    powerMode = rbl_pkg::PwrSleep;
    emergency = 1'b0;
    gpsFitted = 1'b0;
    window(20, 0, 0);
    disc = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    repeat (5) @(negedge ref_clk);
    check({upgradeStart, gatherOnly}, 16'h0000, "foreign disc");
    disc.fat32 = 1'b1;
    @(negedge ref_clk);
    check(upgradeStart, 1'b1, "upgrade start");
    repeat (2) @(negedge ref_clk);
    check(gatherOnly, 1'b1, "gather only");
    check(upgradeStart, 1'b0, "upgrade single pulse");
    window(20, 100, 0);
    disc.done = 1'b1;
    window(20, 140, 0);
    // the disc leaves only once completion flashing is under way
    disc = '0;
    press(7, 1'b0, rbl_pkg::ActReboot);
    press(16, 1'b0, rbl_pkg::ActAccess);
    press(31, 1'b0, rbl_pkg::ActFactory);
    press(22, 1'b0, rbl_pkg::ActNone);
    press(16, 1'b1, rbl_pkg::ActPurge);
    press(31, 1'b1, rbl_pkg::ActNone);
    rst = 1'b1;
    powerMode = rbl_pkg::PwrNormal;
    repeat (2) @(negedge ref_clk);
    check({statusLed, powerLed, txLed, rxLed}, 16'h0000, "leds dark in reset");
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    check(powerLed, 16'h0001, "power green after reset");
    conclude();
  end
endmodule
